// file: common/bss_pkg.sv
// Notes on behaviour
// [RL1] Bit-3 skip test on an addressed nibble advances the program counter by two when set.
// [RL2] When that bit is clear the counter advances by one, in one machine cycle.
// [RL3] The stop instruction halts the oscillator; no instruction executes while stopped.
// [RL4] A falling edge on the wake port wakes it; the next instruction then runs.
// [RL5] Memory minus accumulator loads only the accumulator and updates carry and zero.
// [RL6] Working register minus immediate loads only the accumulator, updating carry and zero.
// [RL7] Write-back memory minus accumulator stores the difference in accumulator and memory.
// [RL8] Write-back register minus immediate stores the difference in accumulator and register.
// [RL9] Zero flag marks a zero result; carry flag holds the borrow-out, for every subtract.
package bss_pkg;
    localparam int INSTR_W = 16;
    localparam int PC_W = 11;
    localparam int NIB_W = 4;
    localparam int ADDR_W = 7;
    localparam int MEM_DEPTH = 128;
    localparam int WREG_W = 4;
    localparam int PORT_W = 4;

    // Opcode fields and their encodings.
    localparam int OP9_LSB = 7;
    localparam int OP8_LSB = 8;
    localparam int IMM_LSB = 4;
    localparam int TESTED_BIT = 3;
    localparam logic [8:0] OP_SKIP_BIT3 = 9'h115;
    localparam logic [8:0] OP_SUB_MEM = 9'h034;
    localparam logic [8:0] OP_SUBWB_MEM = 9'h036;
    localparam logic [7:0] OP_SUB_WREG = 8'h1e;
    localparam logic [7:0] OP_SUBWB_WREG = 8'h1f;
    localparam logic [15:0] OP_STOP = 16'h0f00;

    // Program counter steps.
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;
    localparam logic [PC_W-1:0] PC_SKIP = 11'h002;

    // Reset values.
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
    localparam logic [PORT_W-1:0] PORT_IDLE = 4'hf;

    typedef enum logic {
        BSS_RUN,
        BSS_STOPPED
    } bss_mode_e;
endpackage

// file: rtl/bss_exec.sv
`timescale 1ns/100ps
module bss_exec (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic instrValid,
    input wire logic [bss_pkg::INSTR_W-1:0] instrWord,
    output logic instrReady,
    input wire logic [bss_pkg::PORT_W-1:0] wakeInputPort,
    input wire logic memLoadEn,
    input wire logic [bss_pkg::ADDR_W-1:0] memLoadAddr,
    input wire logic [bss_pkg::NIB_W-1:0] memLoadData,
    input wire logic [bss_pkg::ADDR_W-1:0] memPeekAddr,
    output logic [bss_pkg::NIB_W-1:0] memPeekData,
    output logic [bss_pkg::PC_W-1:0] pcQ,
    output logic [bss_pkg::NIB_W-1:0] resultLatchQ,
    output logic carryFlagQ,
    output logic zeroFlagQ,
    output logic oscHaltedQ
);
    // Reset is released through two flip-flops so every register reset by rstnSync leaves reset together.
    // Only the second stage reads the first, so a release close to the edge cannot reach
    // one register a cycle before another.
    logic rstnMeta;
    logic rstnSync;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstnMeta <= 1'b0;
            rstnSync <= 1'b0;
        end else begin
            rstnMeta <= 1'b1;
            rstnSync <= rstnMeta;
        end
    end

    // Data memory; the working registers are its lowest sixteen nibbles.
    logic [bss_pkg::NIB_W-1:0] dataMem [bss_pkg::MEM_DEPTH];

    // Sequencing, accumulator and flag state: next values for the control registers.
    bss_pkg::bss_mode_e mode_q, mode_d;
    logic [bss_pkg::PC_W-1:0] pc_d;
    logic [bss_pkg::NIB_W-1:0] acc_d;
    logic carry_d;
    logic zero_d;
    logic halted_d;

    // Next value of the registered test read port.
    logic [bss_pkg::NIB_W-1:0] peek_d;

    // Memory write port, shared by the load port and the write-back opcodes.
    logic memWrEn;
    logic [bss_pkg::ADDR_W-1:0] memWrAddr;
    logic [bss_pkg::NIB_W-1:0] memWrData;

    // Decoded fields of the instruction word.
    logic [8:0] op9;
    logic [7:0] op8;
    logic [bss_pkg::ADDR_W-1:0] memAddr;
    logic [bss_pkg::ADDR_W-1:0] wregAddr;
    logic [bss_pkg::NIB_W-1:0] imm;
    logic [bss_pkg::NIB_W-1:0] memNib;
    logic [bss_pkg::NIB_W-1:0] wregNib;
    logic [bss_pkg::NIB_W:0] diffMem;
    logic [bss_pkg::NIB_W:0] diffWreg;

    // Opcode classes; they only act together with a taken instruction.
    logic fire;
    logic isStop;
    logic isSkip;
    logic isSubMem;
    logic isSubWreg;
    logic wbMem;
    logic wbWreg;

    // Wake detection, one falling-edge flag per port line.
    logic [bss_pkg::PORT_W-1:0] portFall;
    logic wakeEdge;

    // Field extraction; the working-register field is zero-extended into a memory address.
    assign op9 = instrWord[bss_pkg::INSTR_W-1:bss_pkg::OP9_LSB];
    assign op8 = instrWord[bss_pkg::INSTR_W-1:bss_pkg::OP8_LSB];
    assign memAddr = instrWord[bss_pkg::ADDR_W-1:0];
    assign wregAddr = {3'h0, instrWord[bss_pkg::WREG_W-1:0]};
    assign imm = instrWord[bss_pkg::IMM_LSB+bss_pkg::NIB_W-1:bss_pkg::IMM_LSB];
    assign memNib = dataMem[memAddr];
    assign wregNib = dataMem[wregAddr];

    // Opcode classes. The stop word is tested first, so it never falls into another class.
    assign isStop = (instrWord == bss_pkg::OP_STOP);
    assign isSkip = !isStop && (op9 == bss_pkg::OP_SKIP_BIT3);
    assign isSubMem = !isStop
        && (op9 == bss_pkg::OP_SUB_MEM || op9 == bss_pkg::OP_SUBWB_MEM);
    assign isSubWreg = !isStop
        && (op8 == bss_pkg::OP_SUB_WREG || op8 == bss_pkg::OP_SUBWB_WREG);
    assign wbMem = isSubMem && (op9 == bss_pkg::OP_SUBWB_MEM);
    assign wbWreg = isSubWreg && (op8 == bss_pkg::OP_SUBWB_WREG);

    // A five-bit difference keeps the borrow in its top bit, one convention for all.
    // Carry set therefore means the minuend was smaller than the subtrahend.
    assign diffMem = {1'b0, memNib} - {1'b0, resultLatchQ}; // RL9
    assign diffWreg = {1'b0, wregNib} - {1'b0, imm}; // RL9

    // No instruction is accepted while the oscillator is halted.
    assign instrReady = (mode_q == bss_pkg::BSS_RUN); // RL3
    // Only an enabled edge takes an instruction, so a frozen core never runs one.
    assign fire = instrValid && instrReady && clkEn;

    // Each port line keeps its own last sample, taken on enabled edges only, so a fall is
    // seen between two enabled edges. The history resets to the idle high level, which
    // keeps a line that rests high from looking like a fall when reset lets go.
    for (genvar b = 0; b < bss_pkg::PORT_W; b++) begin : gPortBit
        logic prevBit_q;
        logic prevBit_d;
        // The next sample is simply the pin as it stands.
        always_comb begin
            prevBit_d = wakeInputPort[b];
        end
        // The history bit freezes with the clock enable like all other state except rstnMeta and rstnSync.
        always_ff @(posedge mclk or negedge rstnSync) begin
            if (!rstnSync) begin
                prevBit_q <= bss_pkg::PORT_IDLE[b];
            end else if (clkEn) begin
                prevBit_q <= prevBit_d;
            end
        end
        // High at the last enabled edge and low now is a falling edge on this line.
        assign portFall[b] = prevBit_q && !wakeInputPort[b]; // RL4
    end

    // Any port line going from high to low counts as a wake edge.
    // Edges while running are ignored, so a fall just before the stop does not end it.
    assign wakeEdge = |portFall; // RL4

    // Next-state logic for sequencing, accumulator and flags.
    always_comb begin
        mode_d = mode_q;
        pc_d = pcQ;
        acc_d = resultLatchQ;
        carry_d = carryFlagQ;
        zero_d = zeroFlagQ;
        unique case (mode_q)
            bss_pkg::BSS_RUN: begin
                if (fire) begin
                    pc_d = pcQ + bss_pkg::PC_STEP; // RL2
                    if (isStop) begin
                        // The counter already points past the stop, so waking resumes there.
                        mode_d = bss_pkg::BSS_STOPPED; // RL3
                    end else if (isSkip) begin
                        // Skip and stop leave the accumulator and both flags alone.
                        if (memNib[bss_pkg::TESTED_BIT]) begin
                            pc_d = pcQ + bss_pkg::PC_SKIP; // RL1
                        end
                    end else if (isSubMem) begin
                        // Both memory forms load the accumulator; only the write-back form stores to memory.
                        acc_d = diffMem[bss_pkg::NIB_W-1:0]; // RL5
                        carry_d = diffMem[bss_pkg::NIB_W]; // RL9
                        zero_d = (diffMem[bss_pkg::NIB_W-1:0] == bss_pkg::NIB_RESET); // RL9
                    end else if (isSubWreg) begin
                        // Both register forms load the accumulator from the same difference.
                        acc_d = diffWreg[bss_pkg::NIB_W-1:0]; // RL6
                        carry_d = diffWreg[bss_pkg::NIB_W]; // RL9
                        zero_d = (diffWreg[bss_pkg::NIB_W-1:0] == bss_pkg::NIB_RESET); // RL9
                    end
                end
            end
            bss_pkg::BSS_STOPPED: begin
                // A fall on any port line is the only way out short of reset; counter, accumulator and flags hold meanwhile.
                if (wakeEdge) begin
                    mode_d = bss_pkg::BSS_RUN; // RL4
                end
            end
        endcase
        halted_d = (mode_d == bss_pkg::BSS_STOPPED); // RL3
    end

    // Control and flag registers; a low clock enable freezes them all.
    always_ff @(posedge mclk or negedge rstnSync) begin
        if (!rstnSync) begin
            mode_q <= bss_pkg::BSS_RUN;
            pcQ <= bss_pkg::PC_RESET;
            resultLatchQ <= bss_pkg::NIB_RESET;
            carryFlagQ <= 1'b0;
            zeroFlagQ <= 1'b0;
            oscHaltedQ <= 1'b0;
        end else if (clkEn) begin
            mode_q <= mode_d;
            pcQ <= pc_d;
            resultLatchQ <= acc_d;
            carryFlagQ <= carry_d;
            zeroFlagQ <= zero_d;
            oscHaltedQ <= halted_d;
        end
    end

    // Memory write selection. A write-back from the running instruction wins over the
    // load port in the same cycle and the load is dropped, so loads must not overlap it.
    always_comb begin
        memWrEn = memLoadEn;
        memWrAddr = memLoadAddr;
        memWrData = memLoadData;
        if (fire && wbMem) begin
            memWrEn = 1'b1; // RL7
            memWrAddr = memAddr; // RL7
            memWrData = diffMem[bss_pkg::NIB_W-1:0]; // RL7
        end else if (fire && wbWreg) begin
            memWrEn = 1'b1; // RL8
            memWrAddr = wregAddr; // RL8
            memWrData = diffWreg[bss_pkg::NIB_W-1:0]; // RL8
        end
    end

    // Memory has no reset: its contents are undefined until loaded, as in the device.
    // Leaving it out of reset also lets it map onto plain storage cells.
    always_ff @(posedge mclk) begin
        if (clkEn && memWrEn) begin
            dataMem[memWrAddr] <= memWrData;
        end
    end

    // Test read port: the addressed nibble as it stands before this edge's write.
    always_comb begin
        peek_d = dataMem[memPeekAddr];
    end

    // The read data is registered, one edge of latency, and freezes with the clock enable.
    always_ff @(posedge mclk or negedge rstnSync) begin
        if (!rstnSync) begin
            memPeekData <= bss_pkg::NIB_RESET;
        end else if (clkEn) begin
            memPeekData <= peek_d;
        end
    end
endmodule

// file: dv/bss_exec_asserts.sv
`timescale 1ns/100ps
module bss_exec_asserts (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic instrReady,
    input wire logic [3:0] wakeInputPort,
    input wire logic [10:0] pcQ,
    input wire logic [3:0] resultLatchQ,
    input wire logic carryFlagQ,
    input wire logic zeroFlagQ,
    input wire logic oscHaltedQ
);
    // Taken instruction and its opcode groups.
    wire tk = clkEn && instrValid && instrReady;
    wire skp = instrWord[15:7] == bss_pkg::OP_SKIP_BIT3;
    wire stp = tk && instrWord == bss_pkg::OP_STOP;
    wire sb = instrWord[15:7] inside {bss_pkg::OP_SUB_MEM, bss_pkg::OP_SUBWB_MEM};
    wire sw = instrWord[15:9] == bss_pkg::OP_SUB_WREG[7:1];
    // Port sample from the last enabled edge, as the core keeps it; a plain one-cycle
    // history would see a different edge whenever the clock enable drops.
    logic [3:0] portSeen;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            portSeen <= 4'hf;
        end else if (clkEn) begin
            portSeen <= wakeInputPort;
        end
    end
    wire fall = clkEn && |(portSeen & ~wakeInputPort);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    chk_skip_step: assert property (tk && skp |=> pcQ - $past(pcQ) inside {11'h1, 11'h2})
        else $error("skip step wrong");
    chk_pc_one: assert property (tk && !skp |=> pcQ == $past(pcQ) + 11'h1)
        else $error("pc step wrong");
    chk_zero_sub: assert property (tk && (sb || sw) |=> zeroFlagQ == (resultLatchQ == 4'h0))
        else $error("zero flag wrong");
    chk_stop_halt: assert property (stp |=> oscHaltedQ && !instrReady)
        else $error("stop not entered");
    chk_halt_hold: assert property (oscHaltedQ |=> $stable(pcQ) && $stable(resultLatchQ))
        else $error("ran while stopped");
    chk_stay_halted: assert property (oscHaltedQ && !fall |=> oscHaltedQ)
        else $error("left stop early");
    chk_wake_up: assert property (oscHaltedQ && fall |=> !oscHaltedQ && instrReady)
        else $error("no wake");
    // The minuend is the result plus the subtrahend; a sum past four bits means a borrow.
    chk_borrow_mem: assert property (tk && sb |=> carryFlagQ
        == (({1'b0, resultLatchQ} + {1'b0, $past(resultLatchQ)}) > 5'h0f))
        else $error("memory borrow wrong");
    chk_borrow_imm: assert property (tk && sw |=> carryFlagQ
        == (({1'b0, resultLatchQ} + {1'b0, $past(instrWord[7:4])}) > 5'h0f))
        else $error("immediate borrow wrong");
    chk_run_no_halt: assert property (!oscHaltedQ && !stp |=> !oscHaltedQ)
        else $error("halted without stop");
endmodule
bind bss_exec bss_exec_asserts chk (.*);

// file: dv/bss_wake_port.sv
`timescale 1ns/100ps
module bss_wake_port (
    input wire logic mclk,
    input wire logic fallReq,
    output logic [3:0] wakeInputPort
);
    // Pins rest high on pull-ups; a request pulls bit 0 low for one cycle.
    always_ff @(posedge mclk) begin
        wakeInputPort <= fallReq ? 4'he : 4'hf;
    end
endmodule

// file: dv/bss_exec_tb.sv
`timescale 1ns/100ps
module bss_exec_tb;
    logic mclk = 1'b0, rstn = 1'b0, instrValid = 1'b0, memLoadEn = 1'b0, fallReq = 1'b0;
    logic clkEn = 1'b1;
    logic [15:0] instrWord = 16'h0000;
    logic [6:0] memLoadAddr = 7'h00, memPeekAddr = 7'h00;
    logic [3:0] memLoadData = 4'h0, memPeekData, resultLatchQ, wakeInputPort;
    logic [10:0] pcQ;
    logic instrReady, carryFlagQ, zeroFlagQ, oscHaltedQ;
    int bad_count = 0, n_checks = 0;
    // Core clock at 10 MHz.
    always #50 mclk = ~mclk;
    bss_exec dut (.mclk, .rstn, .clkEn, .instrValid, .instrWord, .instrReady,
        .wakeInputPort, .memLoadEn, .memLoadAddr, .memLoadData, .memPeekAddr, .memPeekData,
        .pcQ, .resultLatchQ, .carryFlagQ, .zeroFlagQ, .oscHaltedQ);
    bss_wake_port wake (.mclk, .fallReq, .wakeInputPort);
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Flags and accumulator packed as carry, zero, value.
    task automatic fl(input logic [5:0] e);
        cmp(16'({carryFlagQ, zeroFlagQ, resultLatchQ}), 16'(e));
    endtask
    task automatic ex(input logic [15:0] w);
        @(posedge mclk) instrValid <= 1'b1;
        instrWord <= w;
        @(posedge mclk) instrValid <= 1'b0;
        #1;
    endtask
    task automatic ld(input logic [6:0] a, input logic [3:0] d);
        @(posedge mclk) memLoadEn <= 1'b1;
        memLoadAddr <= a;
        memLoadData <= d;
        @(posedge mclk) memLoadEn <= 1'b0;
    endtask
    task automatic pk(input logic [6:0] a, input logic [3:0] e);
        @(posedge mclk) memPeekAddr <= a;
        @(posedge mclk) #1;
        cmp(16'(memPeekData), 16'(e));
    endtask
    // Bit 3 alone decides; the lower three bits set must not cause a skip.
    task automatic t_skip();
        ld(7'h05, 4'h8);
        ld(7'h06, 4'h7);
        ex({bss_pkg::OP_SKIP_BIT3, 7'h05});
        cmp(16'(pcQ), 16'h0002);
        ex({bss_pkg::OP_SKIP_BIT3, 7'h06});
        cmp(16'(pcQ), 16'h0003);
    endtask
    task automatic t_sub();
        ld(7'h20, 4'h3);
        ld(7'h21, 4'h3);
        ld(7'h02, 4'h2);
        ld(7'h22, 4'h1);
        ld(7'h03, 4'h9);
        ex({bss_pkg::OP_SUB_MEM, 7'h20});
        fl(6'h03);
        ex({bss_pkg::OP_SUB_MEM, 7'h21});
        fl(6'h10);
        ex({bss_pkg::OP_SUB_WREG, 8'h52});
        fl(6'h2d);
        ex({bss_pkg::OP_SUBWB_MEM, 7'h22});
        fl(6'h24);
        ex({bss_pkg::OP_SUBWB_WREG, 8'h93});
        fl(6'h10);
        pk(7'h02, 4'h2);
        pk(7'h22, 4'h4);
        pk(7'h03, 4'h0);
        pk(7'h21, 4'h3);
        cmp(16'(pcQ), 16'h0008);
    endtask
    // An instruction offered while stopped must be dropped, not queued.
    task automatic t_stop();
        ex(bss_pkg::OP_STOP);
        cmp(16'({oscHaltedQ, instrReady, pcQ}), 16'h1009);
        ex({bss_pkg::OP_SUB_MEM, 7'h21});
        cmp(16'({oscHaltedQ, resultLatchQ, pcQ}), 16'h8009);
        @(posedge mclk) fallReq <= 1'b1;
        @(posedge mclk) fallReq <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        cmp(16'({oscHaltedQ, instrReady}), 16'h0001);
        ex({bss_pkg::OP_SUB_MEM, 7'h21});
        fl(6'h03);
        cmp(16'(pcQ), 16'h000a);
    endtask
    // A low clock enable must drop an offered instruction and a memory load alike.
    task automatic t_freeze();
        @(posedge mclk) clkEn <= 1'b0;
        ex({bss_pkg::OP_SKIP_BIT3, 7'h05});
        ld(7'h05, 4'h0);
        @(posedge mclk) clkEn <= 1'b1;
        #1;
        cmp(16'(pcQ), 16'h000a);
        ex({bss_pkg::OP_SKIP_BIT3, 7'h05});
        cmp(16'(pcQ), 16'h000c);
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_skip();
        t_sub();
        t_stop();
        t_freeze();
        results();
    end
    // The tests need about 65 cycles; a hang is cut off well beyond that.
    initial begin
        #100000;
        bad_count++;
        results();
    end
endmodule
